// >>> rtl/uds_map.vh
// register offsets, status field positions, reset values and frame timing
// for the serial data and status registers; definitions only
`ifndef UDS_MAP_VH
`define UDS_MAP_VH

`define UDS_ADDR_W         12
`define UDS_OFF_HOLDING    12'h0F40
`define UDS_OFF_STATUS     12'h0F41

`define UDS_ST_RX_AVAIL    7
`define UDS_ST_PAR_FLT     6
`define UDS_ST_OE          5
`define UDS_ST_FRM_FLT     4
`define UDS_ST_BRK         3
`define UDS_ST_TX_EMPTY    2
`define UDS_ST_TX_IDLE     1
`define UDS_ST_CTS         0

`define UDS_RST_RX_AVAIL   1'b0
`define UDS_RST_FLAG       1'b0
`define UDS_RST_TX_EMPTY   1'b1
`define UDS_RST_DATA       8'h00

`define UDS_CLK_HZ         50000000
`define UDS_BAUD           115200
`define UDS_BIT_CLKS       (`UDS_CLK_HZ / `UDS_BAUD)
`define UDS_DATA_BITS      8
`define UDS_STOP_BITS      1
`define UDS_PARITY_EN      0
`define UDS_PARITY_ODD     0

`endif

// >>> rtl/uds_tx.v
// transmit shift engine: frames one byte as start, data, optional parity
// and stop bits; assumes the caller loads only while busy_o is low
`timescale 1ns/1ns
`default_nettype none
`include "uds_map.vh"

module uds_tx #(
  parameter integer BIT_CLKS   = `UDS_BIT_CLKS,
  parameter integer PARITY_EN  = `UDS_PARITY_EN,
  parameter integer PARITY_ODD = `UDS_PARITY_ODD,
  parameter integer STOP_BITS  = `UDS_STOP_BITS
) (
  input  wire       clk_i,
  input  wire       rst_i,
  input  wire       load_i,
  input  wire [7:0] data_i,
  output wire       busy_o,
  output reg        serial_o
);

  localparam integer FRAME = 1 + `UDS_DATA_BITS + PARITY_EN + STOP_BITS;

  reg [FRAME-1:0] shift_r;
  reg [15:0]      tick_r;
  reg [4:0]       left_r;
  wire            par_bit;
  wire [FRAME-1:0] frame_w;

  assign par_bit = (^data_i) ^ (PARITY_ODD != 0);
  // stop bits sit above the optional parity bit, start bit at the bottom
  generate
    if (PARITY_EN != 0)
    begin : g_par
      assign frame_w = {{STOP_BITS{1'b1}}, par_bit, data_i, 1'b0};
    end
    else
    begin : g_nopar
      assign frame_w = {{STOP_BITS{1'b1}}, data_i, 1'b0};
    end
  endgenerate

  assign busy_o = (left_r != 5'd0);

  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      shift_r  <= {FRAME{1'b1}};
      tick_r   <= 16'h0000;
      left_r   <= 5'd0;
      serial_o <= 1'b1;
    end
    else if (load_i && !busy_o)
    begin
      shift_r  <= {1'b1, frame_w[FRAME-1:1]};
      serial_o <= frame_w[0];
      tick_r   <= 16'h0000;
      left_r   <= FRAME[4:0];
    end
    else if (busy_o)
    begin
      if (tick_r == BIT_CLKS[15:0] - 16'h0001)
      begin
        tick_r   <= 16'h0000;
        left_r   <= left_r - 5'd1;
        serial_o <= (left_r == 5'd1) ? 1'b1 : shift_r[0];
        shift_r  <= {1'b1, shift_r[FRAME-1:1]};
      end
      else
      begin
        tick_r <= tick_r + 16'h0001;
      end
    end
  end

endmodule // uds_tx
`default_nettype wire

// >>> rtl/uds_top.v
// serial data and status registers with their receiver and transmitter
// assumes a register-file port with one-cycle read and write strobes,
// a fixed bit rate and pins synchronous to clk_i
//
// Summary of operation
// - a byte written to the transmit holding register is shifted out serially
// - one address writes transmit holding and reads receive holding
// - a received byte lands in the 8-bit receive holding register unless the held byte is unread
// - receive-available sets on a stored byte, clears on holding read unless a hidden overrun surfaces on it
// - parity fault sets on mismatch, clears on holding read
// - overrun sets on unread holding; read clears it only if available is 0
// - framing fault sets on missing stop bit, clears on holding read
// - break seen sets when data, parity and stop are all zero
// - transmit-holding-empty is 1 when free, 0 after a holding write
// - transmitter idle reads 1 only when shifting is finished
// - status bit 0 returns the live clear-to-send pin level
// - an overrun never overwrites the unread byte
// - overrun, and a break on the discarded byte, stay hidden until the valid byte is read
`timescale 1ns/1ns
`default_nettype none
`include "uds_map.vh"

module uds_top #(
  parameter integer BIT_CLKS   = `UDS_BIT_CLKS,
  parameter integer PARITY_EN  = `UDS_PARITY_EN,
  parameter integer PARITY_ODD = `UDS_PARITY_ODD,
  parameter integer STOP_BITS  = `UDS_STOP_BITS
) (
  input  wire                   clk_i,
  input  wire                   rst_i,
  input  wire [`UDS_ADDR_W-1:0] addr_i,
  input  wire                   wr_en_i,
  input  wire                   rd_en_i,
  input  wire [7:0]             wdata_i,
  output reg  [7:0]             rdata_o,
  input  wire                   serial_in_pin_i,
  output wire                   serial_out_pin_o,
  input  wire                   cts_n_i
);

  localparam integer NBITS = `UDS_DATA_BITS + PARITY_EN + STOP_BITS;
  localparam [1:0] RX_IDLE  = 2'd0;
  localparam [1:0] RX_START = 2'd1;
  localparam [1:0] RX_BITS  = 2'd2;
  localparam [15:0] BIT_END  = BIT_CLKS[15:0] - 16'h0001;
  localparam [15:0] HALF_END = BIT_CLKS[16:1] - 16'h0001;

  // register-file decode
  wire sel_hold;
  wire sel_stat;
  wire wr_hold;
  wire rd_hold;

  assign sel_hold = (addr_i == `UDS_OFF_HOLDING);
  assign sel_stat = (addr_i == `UDS_OFF_STATUS);
  assign wr_hold  = wr_en_i && sel_hold;
  assign rd_hold  = rd_en_i && sel_hold;

  // transmit side
  reg  [7:0] tx_hold_r;
  reg        tx_holding_empty_r;
  wire       tx_busy;
  wire       tx_load;
  wire       tx_idle;

  assign tx_load = !tx_holding_empty_r && !tx_busy;
  // a byte waiting in the holding register also counts as not idle
  assign tx_idle = !tx_busy && tx_holding_empty_r;

  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      tx_hold_r          <= `UDS_RST_DATA;
      tx_holding_empty_r <= `UDS_RST_TX_EMPTY;
    end
    else if (wr_hold)
    begin
      // a write in the same cycle as the hand-off leaves the new byte
      // pending, so nothing is lost; an early write replaces the byte
      tx_hold_r          <= wdata_i;
      tx_holding_empty_r <= 1'b0;
    end
    else if (tx_load)
    begin
      tx_holding_empty_r <= 1'b1;
    end
  end

  uds_tx #(
    .BIT_CLKS   (BIT_CLKS),
    .PARITY_EN  (PARITY_EN),
    .PARITY_ODD (PARITY_ODD),
    .STOP_BITS  (STOP_BITS)
  ) u_tx (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .load_i   (tx_load),
    .data_i   (tx_hold_r),
    .busy_o   (tx_busy),
    .serial_o (serial_out_pin_o)
  );

  // receive deserialiser, sampling mid-bit
  reg [1:0]       rx_state_r;
  reg [15:0]      rx_tick_r;
  reg [4:0]       rx_cnt_r;
  reg [NBITS-1:0] rx_sh_r;
  reg             rx_done_r;

  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rx_state_r <= RX_IDLE;
      rx_tick_r  <= 16'h0000;
      rx_cnt_r   <= 5'd0;
      rx_sh_r    <= {NBITS{1'b0}};
      rx_done_r  <= 1'b0;
    end
    else
    begin
      rx_done_r <= 1'b0;
      case (rx_state_r)
        RX_IDLE:
        begin
          rx_tick_r <= 16'h0000;
          if (!serial_in_pin_i)
          begin
            rx_state_r <= RX_START;
          end
        end
        RX_START:
        begin
          if (rx_tick_r == HALF_END)
          begin
            rx_tick_r <= 16'h0000;
            rx_cnt_r  <= 5'd0;
            // a start bit gone high by mid-bit was a glitch
            rx_state_r <= serial_in_pin_i ? RX_IDLE : RX_BITS;
          end
          else
          begin
            rx_tick_r <= rx_tick_r + 16'h0001;
          end
        end
        RX_BITS:
        begin
          if (rx_tick_r == BIT_END)
          begin
            rx_tick_r <= 16'h0000;
            rx_sh_r   <= {serial_in_pin_i, rx_sh_r[NBITS-1:1]};
            rx_cnt_r  <= rx_cnt_r + 5'd1;
            if (rx_cnt_r == NBITS[4:0] - 5'd1)
            begin
              rx_done_r  <= 1'b1;
              rx_state_r <= RX_IDLE;
            end
          end
          else
          begin
            rx_tick_r <= rx_tick_r + 16'h0001;
          end
        end
        default:
        begin
          rx_state_r <= RX_IDLE;
        end
      endcase
    end
  end

  // frame decode of the completed character
  wire [7:0] rx_byte;
  wire       rx_par_bad;
  wire       rx_frm_bad;
  wire       rx_brk;

  assign rx_byte    = rx_sh_r[7:0];
  assign rx_frm_bad = !rx_sh_r[`UDS_DATA_BITS + PARITY_EN];
  assign rx_brk     = ~|rx_sh_r;
  generate
    if (PARITY_EN != 0)
    begin : g_rpar
      assign rx_par_bad = rx_sh_r[8] ^ (^rx_byte) ^ (PARITY_ODD != 0);
    end
    else
    begin : g_rnopar
      assign rx_par_bad = 1'b0;
    end
  endgenerate

  // receive holding register and sticky status
  reg [7:0] rx_hold_r;
  reg       rx_available_r;
  reg       parity_fault_r;
  reg       overrun_r;
  reg       framing_fault_r;
  reg       break_seen_r;
  reg       pend_ovr_r;
  reg       pend_brk_r;

  reg       avail_nxt;
  reg       par_nxt;
  reg       oe_nxt;
  reg       frm_nxt;
  reg       brk_nxt;
  reg       pov_nxt;
  reg       pbk_nxt;
  reg [7:0] hold_nxt;

  always @*
  begin
    avail_nxt = rx_available_r;
    par_nxt   = parity_fault_r;
    oe_nxt    = overrun_r;
    frm_nxt   = framing_fault_r;
    brk_nxt   = break_seen_r;
    pov_nxt   = pend_ovr_r;
    pbk_nxt   = pend_brk_r;
    hold_nxt  = rx_hold_r;
    // effect of a holding read comes first
    if (rd_hold)
    begin
      if (!rx_available_r)
      begin
        oe_nxt  = 1'b0;
        brk_nxt = 1'b0;
      end
      else
      begin
        avail_nxt = 1'b0;
        par_nxt   = 1'b0;
        frm_nxt   = 1'b0;
        // break shown with an overrun leaves with the overrun
        if (!overrun_r)
        begin
          brk_nxt = 1'b0;
        end
      end
      if (pend_ovr_r)
      begin
        // hidden overrun surfaces on a byte that must be discarded
        avail_nxt = 1'b1;
        oe_nxt    = 1'b1;
        brk_nxt   = pend_brk_r;
        par_nxt   = 1'b0;
        frm_nxt   = 1'b0;
        pov_nxt   = 1'b0;
        pbk_nxt   = 1'b0;
      end
    end
    // a character completing in the same cycle still takes effect
    if (rx_done_r)
    begin
      if (avail_nxt)
      begin
        pov_nxt = 1'b1;
        pbk_nxt = pbk_nxt | rx_brk;
      end
      else
      begin
        hold_nxt  = rx_byte;
        avail_nxt = 1'b1;
        par_nxt   = rx_par_bad;
        frm_nxt   = rx_frm_bad;
        brk_nxt   = rx_brk;
      end
    end
  end

  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rx_hold_r       <= `UDS_RST_DATA;
      rx_available_r  <= `UDS_RST_RX_AVAIL;
      parity_fault_r  <= `UDS_RST_FLAG;
      overrun_r       <= `UDS_RST_FLAG;
      framing_fault_r <= `UDS_RST_FLAG;
      break_seen_r    <= `UDS_RST_FLAG;
      pend_ovr_r      <= `UDS_RST_FLAG;
      pend_brk_r      <= `UDS_RST_FLAG;
    end
    else
    begin
      rx_hold_r       <= hold_nxt;
      rx_available_r  <= avail_nxt;
      parity_fault_r  <= par_nxt;
      overrun_r       <= oe_nxt;
      framing_fault_r <= frm_nxt;
      break_seen_r    <= brk_nxt;
      pend_ovr_r      <= pov_nxt;
      pend_brk_r      <= pbk_nxt;
    end
  end

  // status image
  wire [7:0] status_w;

  assign status_w[`UDS_ST_RX_AVAIL] = rx_available_r;
  assign status_w[`UDS_ST_PAR_FLT]  = parity_fault_r;
  assign status_w[`UDS_ST_OE]       = overrun_r;
  assign status_w[`UDS_ST_FRM_FLT]  = framing_fault_r;
  assign status_w[`UDS_ST_BRK]      = break_seen_r;
  assign status_w[`UDS_ST_TX_EMPTY] = tx_holding_empty_r;
  assign status_w[`UDS_ST_TX_IDLE]  = tx_idle;
  assign status_w[`UDS_ST_CTS]      = cts_n_i;

  // read data registered; unmapped reads return zero
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rdata_o <= `UDS_RST_DATA;
    end
    else if (rd_en_i)
    begin
      if (sel_hold)
      begin
        rdata_o <= rx_hold_r;
      end
      else if (sel_stat)
      begin
        rdata_o <= status_w;
      end
      else
      begin
        rdata_o <= `UDS_RST_DATA;
      end
    end
  end

endmodule // uds_top
`default_nettype wire

// >>> tb/uds_top_assertions.sv
// checker for the register port and serial pins of uds_top
// bound to every uds_top; sees only its ports
`timescale 1ns/1ns
`default_nettype none
`include "uds_map.vh"

module uds_chk #(
  parameter integer BIT_CLKS = 16
) (
  input wire logic                   clk_i,
  input wire logic                   rst_i,
  input wire logic [`UDS_ADDR_W-1:0] addr_i,
  input wire logic                   wr_en_i,
  input wire logic                   rd_en_i,
  input wire logic [7:0]             wdata_i,
  input wire logic [7:0]             rdata_o,
  input wire logic                   serial_in_pin_i,
  input wire logic                   serial_out_pin_o,
  input wire logic                   cts_n_i
);
  // a frame has at most ten high bits in a row, so longer means idle
  localparam integer IDLE = 11 * BIT_CLKS;
  integer quiet_r;
  wire rd_st = rd_en_i && addr_i == `UDS_OFF_STATUS;
  wire wr_hd = wr_en_i && addr_i == `UDS_OFF_HOLDING;
  wire unmap = addr_i != `UDS_OFF_HOLDING && addr_i != `UDS_OFF_STATUS;

  always @(posedge clk_i or posedge rst_i)
    if (rst_i)
      quiet_r <= IDLE;
    else if (!serial_out_pin_o)
      quiet_r <= 0;
    else if (quiet_r < IDLE)
      quiet_r <= quiet_r + 1;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_cts_level: assert property (
    rd_st |=> rdata_o[0] == $past(cts_n_i))
    else $error("status bit 0 differs from cts");
  a_unmapped_zero: assert property (
    rd_en_i && unmap |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_hold: assert property (!rd_en_i |=> $stable(rdata_o))
    else $error("read data moved without a read");
  a_tx_start: assert property (
    wr_hd && quiet_r >= IDLE |-> ##[2:3] !serial_out_pin_o)
    else $error("no start bit after write");
  a_bit_width: assert property (
    $fell(serial_out_pin_o) |-> !serial_out_pin_o [*8])
    else $error("low bit too short");
  a_idle_reset: assert property ($fell(rst_i) |-> serial_out_pin_o)
    else $error("line not idle after reset");
  a_busy_not_idle: assert property (
    rd_st && !serial_out_pin_o |=> !rdata_o[1])
    else $error("idle reported while shifting");
  a_write_busy: assert property (
    wr_hd ##[1:2] rd_st |=> !rdata_o[1])
    else $error("idle reported after write");
  a_flag_rda: assert property (
    rd_st ##1 (rdata_o[6] | rdata_o[4]) |-> rdata_o[7])
    else $error("fault bit without byte");
endmodule // uds_chk

bind uds_top uds_chk #(.BIT_CLKS(BIT_CLKS)) chk (
  .clk_i           (clk_i),
  .rst_i           (rst_i),
  .addr_i          (addr_i),
  .wr_en_i         (wr_en_i),
  .rd_en_i         (rd_en_i),
  .wdata_i         (wdata_i),
  .rdata_o         (rdata_o),
  .serial_in_pin_i (serial_in_pin_i),
  .serial_out_pin_o(serial_out_pin_o),
  .cts_n_i         (cts_n_i)
);

`default_nettype wire

// >>> tb/uds_peer.sv
// serial peer on the block's pins: sends frames and collects bytes
// assumes 8 data bits, even parity, one stop bit of BIT_CLKS cycles
`timescale 1ns/1ns
`default_nettype none

module uds_peer #(
  parameter integer BIT_CLKS = 16
) (
  input  wire logic clk_i,
  input  wire logic line_i,
  output var  logic line_o
);
  logic [7:0] got [0:3];
  logic [7:0] sh;
  integer     n_got = 0;
  integer     i;

  initial line_o = 1'b1;

  task send(input logic [7:0] b, input logic bad_par, input logic bad_stop);
    logic [9:0] f;
    integer     k;
    begin
      f = {^b ^ bad_par, b, 1'b0};
      for (k = 0; k < 10; k = k + 1)
      begin
        line_o = f[k];
        repeat (BIT_CLKS) @(negedge clk_i);
      end
      line_o = ~bad_stop;
      repeat (BIT_CLKS / 2 + 4) @(negedge clk_i);
      // a spoiled stop is cut short so that no false start follows it
      line_o = 1'b1;
      repeat (BIT_CLKS / 2 - 4) @(negedge clk_i);
    end
  endtask

  always @(negedge line_i)
  begin
    repeat (BIT_CLKS / 2) @(posedge clk_i);
    for (i = 0; i < 8; i = i + 1)
    begin
      repeat (BIT_CLKS) @(posedge clk_i);
      sh[i] = line_i; // lsb first
    end
    got[n_got] = sh;
    n_got = n_got + 1;
    repeat (BIT_CLKS * 2) @(posedge clk_i);
  end
endmodule // uds_peer

`default_nettype wire

// >>> tb/uds_top_bench.sv
// self-checking bench for uds_top with a serial peer on its pins
// assumes uds_peer and the bound checker are compiled alongside
`timescale 1ns/1ns
`default_nettype none
`include "uds_map.vh"

module uds_top_bench;
  localparam integer BIT = 16;
  logic                   clk = 1'b0;
  logic                   rst = 1'b1;
  logic [`UDS_ADDR_W-1:0] addr = 12'h0000;
  logic                   wr_en = 1'b0;
  logic                   rd_en = 1'b0;
  logic [7:0]             wdata = 8'h00;
  logic                   cts_n = 1'b1;
  logic [7:0]             d;
  wire  [7:0]             rdata;
  wire                    rx_line;
  wire                    tx_line;
  integer                 fails = 0;
  integer                 checks_done = 0;
  integer                 k;

  always #10 clk = ~clk;

  uds_top #(.BIT_CLKS(BIT), .PARITY_EN(1), .PARITY_ODD(0),
            .STOP_BITS(1)) dut (
    .clk_i(clk), .rst_i(rst), .addr_i(addr), .wr_en_i(wr_en),
    .rd_en_i(rd_en), .wdata_i(wdata), .rdata_o(rdata),
    .serial_in_pin_i(rx_line), .serial_out_pin_o(tx_line),
    .cts_n_i(cts_n));
  uds_peer #(.BIT_CLKS(BIT)) peer (
    .clk_i(clk), .line_i(tx_line), .line_o(rx_line));

  task chk(input logic [7:0] seen, input logic [7:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp)
      begin
        fails = fails + 1;
        $display("MISMATCH at %0t: saw %h wanted %h", $time, seen, exp);
      end
    end
  endtask

  task wr(input logic [11:0] a, input logic [7:0] v);
    begin
      @(negedge clk);
      addr = a;
      wdata = v;
      wr_en = 1'b1;
      @(negedge clk);
      wr_en = 1'b0;
    end
  endtask

  task rd(input logic [11:0] a);
    begin
      @(negedge clk);
      addr = a;
      rd_en = 1'b1;
      @(negedge clk);
      rd_en = 1'b0;
      d = rdata;
    end
  endtask

  // bounded poll of the status register until all bits of m are set
  task wait_st(input logic [7:0] m);
    integer i;
    begin
      d = 8'h00;
      for (i = 0; i < 300 && (d & m) !== m; i = i + 1)
        rd(`UDS_OFF_STATUS);
      chk(d & m, m);
    end
  endtask

  task t_reset;
    begin
      for (k = 0; k < 2; k = k + 1)
      begin
        cts_n = k[0];
        rd(`UDS_OFF_STATUS);
        chk(d, {7'h03, k[0]});
      end
      rd(12'h0F42);
      chk(d, 8'h00);
      wr(`UDS_OFF_STATUS, 8'hFF);
      rd(`UDS_OFF_STATUS);
      chk(d, 8'h07);
    end
  endtask

  task t_tx;
    begin
      wr(`UDS_OFF_HOLDING, 8'hA5);
      rd(`UDS_OFF_STATUS);
      chk(d & 8'h02, 8'h00);
      wait_st(8'h04);
      wr(`UDS_OFF_HOLDING, 8'h3C);
      rd(`UDS_OFF_STATUS);
      chk(d & 8'h06, 8'h00);
      wait_st(8'h02);
      chk(peer.got[0], 8'hA5);
      chk(peer.got[1], 8'h3C);
    end
  endtask

  task rx_one(input logic [7:0] b, input logic pb, input logic sb,
              input logic [7:0] st);
    begin
      peer.send(b, pb, sb);
      rd(`UDS_OFF_STATUS);
      chk(d & 8'hF8, st);
      rd(`UDS_OFF_HOLDING);
      chk(d, b);
      rd(`UDS_OFF_STATUS);
      chk(d & 8'hF8, 8'h00);
    end
  endtask

  task t_rx;
    begin
      rx_one(8'h5A, 1'b0, 1'b0, 8'h80);
      rx_one(8'hC3, 1'b1, 1'b0, 8'hC0);
      rx_one(8'h96, 1'b0, 1'b1, 8'h90);
      rx_one(8'h00, 1'b0, 1'b1, 8'h98);
    end
  endtask

  task t_ovr;
    begin
      peer.send(8'h11, 1'b0, 1'b0);
      peer.send(8'h22, 1'b0, 1'b0);
      rd(`UDS_OFF_STATUS);
      chk(d & 8'hF8, 8'h80);
      rd(`UDS_OFF_HOLDING);
      chk(d, 8'h11);
      rd(`UDS_OFF_STATUS);
      chk(d & 8'hF8, 8'hA0);
      rd(`UDS_OFF_HOLDING);
      rd(`UDS_OFF_STATUS);
      chk(d & 8'hF8, 8'h20);
      rd(`UDS_OFF_HOLDING);
      rd(`UDS_OFF_STATUS);
      chk(d & 8'hF8, 8'h00);
    end
  endtask

  task results;
    begin
      $display("checks %0d, mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask

  initial
  begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    t_reset;
    t_tx;
    t_rx;
    t_ovr;
    results;
  end

  // the whole run needs about 1500 cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    fails = fails + 1;
    results;
  end
endmodule // uds_top_bench

`default_nettype wire
